// ===== src/bilevel_bank_map.vh
// Register offsets, field positions and reset values for the bank comparator and current DAC registers.
`ifndef BILEVEL_BANK_MAP_VH
`define BILEVEL_BANK_MAP_VH
`define ADDR_BANK_COMPARE_SELECT   5'h0C
`define ADDR_BANK_COMPARE_STATUS   5'h0D
`define ADDR_CURRENT_DAC_HIGH_BITS 5'h0E
`define ADDR_CURRENT_DAC_LOW_BITS  5'h0F
`define SEL_EXT_THRESHOLD_BIT      7
`define SEL_BANK_SWITCH_BIT        3
`define SEL_BANK_MSB               2
`define SEL_BANK_LSB               0
`define DAC_LOW_KEEP_MASK          8'h03
`define RESET_BANK_SELECT          8'h00
`define RESET_DAC_HIGH             8'h00
`define RESET_DAC_LOW              8'h00
`define RESET_DAC_CODE             10'h000
`define MUX_SOURCE_MAX_CODE        10'h01F
`endif

// ===== src/bank_input_route.v
// Bank input router: picks one group of eight comparator results out of sixty-four channels.
module bank_input_route #(
  parameter CHANNELS = 64,
  parameter GROUP    = 8
) (
  input  wire [CHANNELS-1:0] channel_above,
  input  wire [2:0]          bank_index,
  output wire [GROUP-1:0]    group_above
);
  // Bit k of the group is channel 8n+k+1, so bit 0 is the lowest channel of the bank.
  genvar k;
  generate
    for (k = 0; k < GROUP; k = k + 1) begin : g_bit
      assign group_above[k] = channel_above[{bank_index, 3'h0} + k];
    end
  endgenerate
endmodule

// ===== src/bilevel_bank_and_dac_regs.v
// Register bank for the bank bi-level comparators and the staged 10-bit current DAC.
`include "bilevel_bank_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// - Switch enable set routes the selected eight-channel bank to the comparators.
// - Switch enable clear uses mux channel select registers; bank bits ignored.
// - Bank code n selects channels 8n+1 through 8n+8.
// - Bits six to four are stored and read back, with no function.
// - Bit seven picks external threshold pin, else internal reference.
// - Bank selection register resets to zero.
// - Status register shows live outputs of the eight bank comparators.
// - Status bit is one when input exceeds the common threshold.
// - Status bit zero is lowest channel of bank, bit seven highest.
// - High register holds eight upper code bits, low register two lower.
// - Low register keeps two bits; upper six read zero.
// - Writing the high register joins both parts and updates the DAC at once.
// - DAC is powered down while function enable bit two is zero.
// - Source select zero uses four-bit source; DAC drives complementary pins.
// - General mode accepts codes 0 to 1023, complementary outputs.
// - Third mode: DAC acts as five-bit mux current source.
// - Source select one deselects four-bit source and assigns the DAC.
module bilevel_bank_and_dac_regs #(
  parameter CHANNELS = 64
) (
  input  wire                clk_sys,
  input  wire                nrst,
  input  wire                reg_write,
  input  wire                reg_read,
  input  wire [4:0]          reg_addr,
  input  wire [7:0]          reg_wdata,
  output reg  [7:0]          reg_rdata,
  input  wire [CHANNELS-1:0] channel_above,
  input  wire [7:0]          mux_select_above,
  input  wire                dac_enable,
  input  wire                mux_source_select,
  output wire                bank_switch_enable,
  output wire [2:0]          bank_index,
  output wire                external_threshold_select,
  output wire [9:0]          current_dac_code,
  output wire                dac_powered,
  output wire                dac_pins_active,
  output wire                dac_mux_source_active,
  output wire                four_bit_current_source_active,
  output wire                mux_code_out_of_range
);

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers. Comparator results and mode pins come from analog or
  // other logic outside this clock, so each passes two flops first.
  reg  [CHANNELS-1:0] chan_meta_q;
  reg  [CHANNELS-1:0] chan_sync_q;
  reg  [7:0]          musel_meta_q;
  reg  [7:0]          musel_sync_q;
  reg  [1:0]          mode_meta_q;
  reg  [1:0]          mode_sync_q;

  // The first stage is read only by the second stage.
  always @(posedge clk_sys) begin
    if (!nrst) begin
      chan_meta_q  <= {CHANNELS{1'b0}};
      chan_sync_q  <= {CHANNELS{1'b0}};
      musel_meta_q <= 8'h00;
      musel_sync_q <= 8'h00;
      mode_meta_q  <= 2'h0;
      mode_sync_q  <= 2'h0;
    end else begin
      chan_meta_q  <= channel_above;
      chan_sync_q  <= chan_meta_q;
      musel_meta_q <= mux_select_above;
      musel_sync_q <= musel_meta_q;
      mode_meta_q  <= {mux_source_select, dac_enable};
      mode_sync_q  <= mode_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Writable registers.
  reg  [7:0] bank_select_q;
  reg  [7:0] dac_high_q;
  reg  [1:0] dac_low_q;
  reg  [9:0] dac_code_q;
  wire       wr_select;
  wire       wr_high;
  wire       wr_low;

  assign wr_select = reg_write && (reg_addr == `ADDR_BANK_COMPARE_SELECT);
  assign wr_high   = reg_write && (reg_addr == `ADDR_CURRENT_DAC_HIGH_BITS);
  assign wr_low    = reg_write && (reg_addr == `ADDR_CURRENT_DAC_LOW_BITS);

  // Selection register stores all eight bits, unused ones included.
  always @(posedge clk_sys) begin
    if (!nrst) begin
      bank_select_q <= `RESET_BANK_SELECT;
    end else if (wr_select) begin
      bank_select_q <= reg_wdata;
    end
  end

  // The low register is only staging; the DAC does not move until the high
  // register is written, so a two-write update never shows a torn code.
  always @(posedge clk_sys) begin
    if (!nrst) begin
      dac_high_q <= `RESET_DAC_HIGH;
      dac_low_q  <= 2'h0;
      dac_code_q <= `RESET_DAC_CODE;
    end else begin
      if (wr_low) begin
        dac_low_q <= reg_wdata[1:0];
      end
      if (wr_high) begin
        dac_high_q <= reg_wdata;
        dac_code_q <= {reg_wdata, dac_low_q};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Comparator routing and status.
  wire [7:0] bank_group_above;
  wire [7:0] status_live;

  bank_input_route #(
    .CHANNELS (CHANNELS),
    .GROUP    (8)
  ) u_route (
    .channel_above (chan_sync_q),
    .bank_index    (bank_select_q[`SEL_BANK_MSB:`SEL_BANK_LSB]),
    .group_above   (bank_group_above)
  );

  assign bank_switch_enable        = bank_select_q[`SEL_BANK_SWITCH_BIT];
  assign bank_index                = bank_select_q[`SEL_BANK_MSB:`SEL_BANK_LSB];
  assign external_threshold_select = bank_select_q[`SEL_EXT_THRESHOLD_BIT];

  // Bank bits are ignored when switching is off; mux-select results take over.
  assign status_live = bank_switch_enable ? bank_group_above : musel_sync_q;

  ////////////////////////////////////////////////////////////////////////////////
  // DAC mode decode: off, complementary pins, or internal mux source.
  assign current_dac_code               = dac_code_q;
  assign dac_powered                    = mode_sync_q[0];
  assign dac_pins_active                = mode_sync_q[0] && !mode_sync_q[1];
  assign dac_mux_source_active          = mode_sync_q[0] && mode_sync_q[1];
  assign four_bit_current_source_active = !mode_sync_q[1];
  // Flags a host breach of the 0..31 limit; the code is still applied unchanged.
  assign mux_code_out_of_range = mode_sync_q[1] && (dac_code_q > `MUX_SOURCE_MAX_CODE);

  ////////////////////////////////////////////////////////////////////////////////
  // Read data is registered; a read returns the value one cycle later.
  // Writes to the status offset match no write strobe, so they do nothing.
  always @(posedge clk_sys) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        `ADDR_BANK_COMPARE_SELECT:   reg_rdata <= bank_select_q;
        `ADDR_BANK_COMPARE_STATUS:   reg_rdata <= status_live;
        `ADDR_CURRENT_DAC_HIGH_BITS: reg_rdata <= dac_high_q;
        `ADDR_CURRENT_DAC_LOW_BITS:  reg_rdata <= {6'h00, dac_low_q};
        default:                     reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule

// ===== dv/bilevel_bank_and_dac_regs_asserts.sv
// Port-level assertions for the bank comparator and current DAC register block.
module bilevel_bank_and_dac_regs_asserts #(parameter CHANNELS = 64) (
  input wire logic       clk_sys, nrst, reg_write, reg_read, bank_switch_enable, external_threshold_select,
  input wire logic       dac_powered, dac_pins_active, dac_mux_source_active, four_bit_current_source_active,
  input wire logic       mux_code_out_of_range,
  input wire logic [2:0] bank_index,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata, reg_rdata,
  input wire logic [9:0] current_dac_code
);
  // One clock domain, so clock and reset are stated once for every check.
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  AST_SEL: assert property (reg_write && reg_addr == 5'h0C |=>
    {external_threshold_select, bank_switch_enable, bank_index} == {$past(reg_wdata[7]), $past(reg_wdata[3:0])})
    else $error("select write lost");
  AST_HI: assert property (reg_write && reg_addr == 5'h0E |=> current_dac_code[9:2] == $past(reg_wdata))
    else $error("high bits lost");
  AST_HOLD: assert property (!(reg_write && reg_addr == 5'h0E) |=> $stable(current_dac_code))
    else $error("code moved without high write");
  AST_LOW: assert property (reg_read && reg_addr == 5'h0F |=> reg_rdata[7:2] == 6'h00)
    else $error("low register upper bits set");
  AST_OFF: assert property (!dac_powered |-> !(dac_pins_active || dac_mux_source_active))
    else $error("unpowered converter active");
  AST_PINS: assert property (dac_pins_active |-> four_bit_current_source_active)
    else $error("pins active without four-bit source");
  AST_MUX: assert property (dac_mux_source_active |-> dac_powered && !four_bit_current_source_active)
    else $error("mux source mode inconsistent");
  AST_RANGE: assert property (mux_code_out_of_range == (!four_bit_current_source_active && current_dac_code > 10'h01F))
    else $error("range flag wrong");
  AST_RST: assert property ($rose(nrst) |-> current_dac_code == 10'h000 && {bank_switch_enable, bank_index} == 4'h0)
    else $error("reset values wrong");
  // Main scenarios: bank status read, mux source mode, out-of-range code.
  cover property (reg_read && reg_addr == 5'h0D && bank_switch_enable);
  cover property (dac_mux_source_active);
  cover property (mux_code_out_of_range);
endmodule

// ===== dv/host_model.sv
// Host controller model that drives the register strobes.
module host_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_write = 1'b0,
  output logic            reg_read = 1'b0,
  output logic      [4:0] reg_addr = 5'h00,
  output logic      [7:0] reg_wdata = 8'h00
);
  // One strobe cycle per access; the answer is taken just after the edge that accepts it.
  task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys);
    {reg_write, reg_read, reg_addr, reg_wdata} <= {w, !w, a, d};
    @(posedge clk_sys);
    {reg_write, reg_read} <= 2'h0;
    #1 q = reg_rdata;
  endtask
  // The low pair goes first so the high write picks it up.
  task automatic set_dac(input logic [9:0] c);
    logic [7:0] q;
    xfer(1'b1, 5'h0F, {6'h00, c[1:0]}, q);
    xfer(1'b1, 5'h0E, c[9:2], q);
  endtask
endmodule

// ===== dv/test_bilevel_bank_and_dac_regs.sv
// Self-checking bench for the bank comparator and current DAC registers.
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module test_bilevel_bank_and_dac_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 0, nrst = 0, dac_enable = 0, mux_source_select = 0;
  logic        reg_write, reg_read, bank_switch_enable, external_threshold_select, dac_powered, dac_pins_active;
  logic        dac_mux_source_active, four_bit_current_source_active, mux_code_out_of_range;
  logic [2:0]  bank_index;
  logic [4:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, q, mux_select_above = 8'h00;
  logic [9:0]  current_dac_code;
  logic [63:0] channel_above = 64'hF0E1D2C3B4A59687;
  int          err_total = 0, checks = 0;
  // Each row: select byte written, then the status byte that bank must show.
  logic [15:0] rows [8] = '{16'h0887, 16'h1996, 16'h2AA5, 16'h3BB4, 16'h4CC3, 16'h5DD2, 16'h6EE1, 16'hFFF0};
  wire  [4:0]  modes = {dac_powered, dac_pins_active, dac_mux_source_active,
                        four_bit_current_source_active, mux_code_out_of_range};
  bilevel_bank_and_dac_regs bilevel_bank_and_dac_regs_inst (.*);
  host_model host_model_inst (.*);
  initial forever #50 clk_sys = ~clk_sys;
  task automatic summarize;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // A hang costs a mismatch; the tests need far fewer cycles than this.
  initial begin
    #600000 err_total++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      host_model_inst.xfer(1'b1, 5'h0C, rows[i][15:8], q);
      repeat (3) @(posedge clk_sys);
      `CHK({external_threshold_select, bank_switch_enable, bank_index}, {rows[i][15], rows[i][11:8]})
      host_model_inst.xfer(1'b0, 5'h0C, 8'h00, q);
      `CHK(q, rows[i][15:8])
      host_model_inst.xfer(1'b0, 5'h0D, 8'h00, q);
      `CHK(q, rows[i][7:0])
    end
    // Switch off with bank bits set; a status write must not stick.
    host_model_inst.xfer(1'b1, 5'h0C, 8'h07, q);
    @(posedge clk_sys) mux_select_above <= 8'h5A;
    repeat (3) @(posedge clk_sys);
    host_model_inst.xfer(1'b1, 5'h0D, 8'hFF, q);
    host_model_inst.xfer(1'b0, 5'h0D, 8'h00, q);
    `CHK(q, 8'h5A)
    // Low bits alone leave the applied code alone until the high write.
    host_model_inst.xfer(1'b1, 5'h0F, 8'hFF, q);
    host_model_inst.xfer(1'b0, 5'h0F, 8'h00, q);
    `CHK({q, current_dac_code}, 18'h00C00)
    host_model_inst.set_dac(10'h3FF);
    `CHK(current_dac_code, 10'h3FF)
    host_model_inst.set_dac(10'h297);
    host_model_inst.xfer(1'b0, 5'h0E, 8'h00, q);
    `CHK({q, current_dac_code}, 18'h29697)
    host_model_inst.xfer(1'b0, 5'h1F, 8'h00, q);
    `CHK(q, 8'h00)
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_sys) {dac_enable, mux_source_select} <= m[1:0];
      repeat (4) @(posedge clk_sys);
      #1 `CHK(modes, {m[1], m[1] & !m[0], m[1] & m[0], !m[0], m[0]})
    end
    host_model_inst.set_dac(10'h01F);
    `CHK({dac_mux_source_active, mux_code_out_of_range}, 2'h2)
    @(posedge clk_sys) nrst <= 1'b0;
    @(posedge clk_sys) nrst <= 1'b1;
    #1 `CHK({current_dac_code, bank_switch_enable}, 11'h000)
    host_model_inst.xfer(1'b0, 5'h0C, 8'h00, q);
    `CHK(q, 8'h00)
    summarize();
  end
endmodule
bind bilevel_bank_and_dac_regs bilevel_bank_and_dac_regs_asserts #(.CHANNELS(CHANNELS)) chk_inst (.*);
